// ==== rtl/dlct_pkg.sv ====
// package of constants and types for the dual counter/timers
package dlct_pkg;
  // register indices on the plain register port
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_MODE = 4'h1;
  localparam logic [3:0] ADDR_T0L = 4'h2;
  localparam logic [3:0] ADDR_T1L = 4'h3;
  localparam logic [3:0] ADDR_T0H = 4'h4;
  localparam logic [3:0] ADDR_T1H = 4'h5;
  localparam logic [3:0] ADDR_CKSEL = 4'h6;
  localparam logic [3:0] ADDR_IEN = 4'h7;
  // control register fields
  localparam int CTRL_TF1 = 7;
  localparam int CTRL_TR1 = 6;
  localparam int CTRL_TF0 = 5;
  localparam int CTRL_TR0 = 4;
  // mode register: timer 1 in bits 7:4, timer 0 in bits 3:0
  localparam int MODE_T1_LSB = 4;
  localparam int MODE_GATE = 3;
  localparam int MODE_CT = 2;
  // clock select register fields
  localparam int CKSEL_T1M = 4;
  localparam int CKSEL_T0M = 3;
  // interrupt enable register fields
  localparam int IEN_ET1 = 3;
  localparam int IEN_ET0 = 1;
  // external input polarity fields, held in the interrupt enable register
  localparam int IEN_POL0 = 4;
  localparam int IEN_POL1 = 5;
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  // prescale divisors by field value
  localparam int PRE_DIV0 = 12;
  localparam int PRE_DIV1 = 4;
  localparam int PRE_DIV2 = 48;
  localparam int PRE_W = 6;
  localparam logic [PRE_W-1:0] PRE_CNT0 = 6'(PRE_DIV0 - 1);
  localparam logic [PRE_W-1:0] PRE_CNT1 = 6'(PRE_DIV1 - 1);
  localparam logic [PRE_W-1:0] PRE_CNT2 = 6'(PRE_DIV2 - 1);
  typedef enum logic [1:0] {
    MODE_13BIT,
    MODE_16BIT,
    MODE_8RELOAD,
    MODE_SPLIT
  } dlct_mode_type;
  typedef struct packed {
    logic gate;
    logic count_sel;
    logic [1:0] mode;
  } dlct_tcfg_type;
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } dlct_bus_type;
endpackage : dlct_pkg

// ==== rtl/dlct_edge.sv ====
// two-flop pin sampler with falling-edge pulse
`timescale 1ns/1ns
module dlct_edge
  import dlct_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pin_i,
  output logic level_o,
  output logic fall_o
);
  logic meta_q;
  logic sync_q;
  logic last_q;

  // synchronous sampling, first flop read only by second
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      last_q <= 1'b1;
    end else begin
      meta_q <= pin_i;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign level_o = sync_q;
  assign fall_o = last_q & ~sync_q;

  AST_FALL_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
    fall_o |=> !fall_o) else $error("edge pulse longer than one cycle");
endmodule : dlct_edge

// ==== rtl/dlct_timers.sv ====
// two legacy counter/timers with register port
`timescale 1ns/1ns
// Overview of operation
// - both timers: 13, 16, 8-reload; split on first
// - three count clock sources per timer: pin edge, system or prescaled
// - prescaler divides; timer picks divided or system
// - counter mode counts falling event pin edges
// - pin sampled synchronously, up to half rate
// - count held as low and high bytes
// - control register holds run bits and flags
// - overflow irq forwarded only when enabled
// - per-timer mode bits; first split takes second run bit, flag, pin clock
// - 13-bit: high byte msbs, low bits 4:0
// - 13-bit low byte top three bits keep their value
// - 13-bit wrap sets flag, raises irq
// - second timer same 13-bit behaviour
// - count when run and gate clear or input active
// - counter select: pin; else clock select bit
// - 8-bit reload: low counts, high reloads
// - split: high byte uses second run, flag
module dlct_timers
  import dlct_pkg::*;
(
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  input wire logic [3:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [7:0] RDATA_O,
  input wire logic FIRST_EVENT_PIN_I,
  input wire logic SECOND_EVENT_PIN_I,
  input wire logic FIRST_EXT_INT_I,
  input wire logic SECOND_EXT_INT_I,
  input wire logic [1:0] PRESCALE_SELECT_I,
  output logic FIRST_IRQ_O,
  output logic SECOND_IRQ_O
);
  dlct_bus_type bus;
  logic [7:0] ctrl_q;
  logic [7:0] mode_q;
  logic [7:0] cksel_q;
  logic [7:0] ien_q;
  logic [7:0] t0l_q;
  logic [7:0] t0h_q;
  logic [7:0] t1l_q;
  logic [7:0] t1h_q;
  logic [7:0] rdata_q;
  logic [PRE_W-1:0] pre_cnt_q;
  logic [PRE_W-1:0] pre_top;
  logic pre_tick;
  logic [1:0] pre_sel_q;
  logic [1:0] pre_meta_q;
  logic ext_meta0_q;
  logic ext_meta1_q;
  logic ext0_q;
  logic ext1_q;
  logic ev0_fall;
  logic ev1_fall;
  dlct_tcfg_type cfg0;
  dlct_tcfg_type cfg1;
  dlct_mode_type m0;
  dlct_mode_type m1;
  logic tick_clk0;
  logic tick_clk1;
  logic inc0;
  logic inc1;
  logic inc0h;
  logic en0;
  logic en1;
  logic ovf0;
  logic ovf1;
  logic ovf0h;
  logic [7:0] t0l_d;
  logic [7:0] t0h_d;
  logic [7:0] t1l_d;
  logic [7:0] t1h_d;

  assign bus = '{addr: ADDR_I, wdata: WDATA_I, wr: WR_I, rd: RD_I};
  assign cfg0 = mode_q[3:0];
  assign cfg1 = mode_q[7:4];
  assign m0 = dlct_mode_type'(cfg0.mode);
  assign m1 = dlct_mode_type'(cfg1.mode);

  // pin samplers for event inputs
  dlct_edge u_ev0 (
    .clk_i(REF_CLK_I),
    .rst_i(RST_I),
    .pin_i(FIRST_EVENT_PIN_I),
    .level_o(),
    .fall_o(ev0_fall)
  );
  dlct_edge u_ev1 (
    .clk_i(REF_CLK_I),
    .rst_i(RST_I),
    .pin_i(SECOND_EVENT_PIN_I),
    .level_o(),
    .fall_o(ev1_fall)
  );

  // external gate inputs and prescale select synchronised
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ext_meta0_q <= 1'b0;
      ext_meta1_q <= 1'b0;
      ext0_q <= 1'b0;
      ext1_q <= 1'b0;
      pre_meta_q <= 2'h0;
      pre_sel_q <= 2'h0;
    end else begin
      ext_meta0_q <= FIRST_EXT_INT_I;
      ext_meta1_q <= SECOND_EXT_INT_I;
      ext0_q <= ext_meta0_q;
      ext1_q <= ext_meta1_q;
      pre_meta_q <= PRESCALE_SELECT_I;
      pre_sel_q <= pre_meta_q;
    end
  end

  // shared prescaler; value 3 falls back to divide by 4
  always_comb begin
    if (pre_sel_q == 2'h0) begin
      pre_top = PRE_CNT0;
    end else if (pre_sel_q == 2'h2) begin
      pre_top = PRE_CNT2;
    end else begin
      pre_top = PRE_CNT1;
    end
  end

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      pre_cnt_q <= '0;
    end else if (pre_cnt_q >= pre_top) begin
      pre_cnt_q <= '0;
    end else begin
      pre_cnt_q <= pre_cnt_q + 6'h01;
    end
  end
  assign pre_tick = (pre_cnt_q >= pre_top);

  // clock source per timer: pin edge, system clock or prescaled
  assign tick_clk0 = cksel_q[CKSEL_T0M] ? 1'b1 : pre_tick;
  assign tick_clk1 = cksel_q[CKSEL_T1M] ? 1'b1 : pre_tick;
  assign en0 = ctrl_q[CTRL_TR0] & (~cfg0.gate | (ext0_q == ien_q[IEN_POL0]));
  assign en1 = ctrl_q[CTRL_TR1] & (~cfg1.gate | (ext1_q == ien_q[IEN_POL1]));
  assign inc0 = en0 & (cfg0.count_sel ? ev0_fall : tick_clk0);
  // split high byte is timer only, run by second run bit
  assign inc0h = ctrl_q[CTRL_TR1] & tick_clk0;
  // second timer stops in split mode, no pin clock when first split
  assign inc1 = en1 & (m1 != MODE_SPLIT) &
    (cfg1.count_sel ? (ev1_fall & (m0 != MODE_SPLIT)) : tick_clk1);

  // first timer count
  always_comb begin
    t0l_d = t0l_q;
    t0h_d = t0h_q;
    ovf0 = 1'b0;
    ovf0h = 1'b0;
    case (m0)
      MODE_13BIT: begin
        if (inc0) begin
          {t0h_d, t0l_d[4:0]} = {t0h_q, t0l_q[4:0]} + 13'h0001;
          ovf0 = (t0h_q == 8'hff) && (t0l_q[4:0] == 5'h1f);
        end
      end
      MODE_16BIT: begin
        if (inc0) begin
          {t0h_d, t0l_d} = {t0h_q, t0l_q} + 16'h0001;
          ovf0 = ({t0h_q, t0l_q} == 16'hffff);
        end
      end
      MODE_8RELOAD: begin
        if (inc0) begin
          ovf0 = (t0l_q == 8'hff);
          t0l_d = ovf0 ? t0h_q : t0l_q + 8'h01;
        end
      end
      default: begin
        if (inc0) begin
          t0l_d = t0l_q + 8'h01;
          ovf0 = (t0l_q == 8'hff);
        end
        if (inc0h) begin
          t0h_d = t0h_q + 8'h01;
          ovf0h = (t0h_q == 8'hff);
        end
      end
    endcase
  end

  // second timer count, 13-bit, 16-bit and 8-bit reload as first, no split form
  always_comb begin
    t1l_d = t1l_q;
    t1h_d = t1h_q;
    ovf1 = 1'b0;
    if (inc1) begin
      case (m1)
        MODE_13BIT: begin
          {t1h_d, t1l_d[4:0]} = {t1h_q, t1l_q[4:0]} + 13'h0001;
          ovf1 = (t1h_q == 8'hff) && (t1l_q[4:0] == 5'h1f);
        end
        MODE_16BIT: begin
          {t1h_d, t1l_d} = {t1h_q, t1l_q} + 16'h0001;
          ovf1 = ({t1h_q, t1l_q} == 16'hffff);
        end
        default: begin
          ovf1 = (t1l_q == 8'hff);
          t1l_d = ovf1 ? t1h_q : t1l_q + 8'h01;
        end
      endcase
    end
  end

  // count registers, byte writes take priority over counting
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      t0l_q <= RST_BYTE;
      t0h_q <= RST_BYTE;
      t1l_q <= RST_BYTE;
      t1h_q <= RST_BYTE;
    end else begin
      t0l_q <= (bus.wr && bus.addr == ADDR_T0L) ? bus.wdata : t0l_d;
      t0h_q <= (bus.wr && bus.addr == ADDR_T0H) ? bus.wdata : t0h_d;
      t1l_q <= (bus.wr && bus.addr == ADDR_T1L) ? bus.wdata : t1l_d;
      t1h_q <= (bus.wr && bus.addr == ADDR_T1H) ? bus.wdata : t1h_d;
    end
  end

  // control register; overflow set wins over software clear
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ctrl_q <= RST_BYTE;
    end else begin
      if (bus.wr && bus.addr == ADDR_CTRL) begin
        ctrl_q <= bus.wdata;
      end
      if (ovf0) begin
        ctrl_q[CTRL_TF0] <= 1'b1;
      end
      // second flag from split high byte or from second timer
      if ((m0 == MODE_SPLIT) ? ovf0h : ovf1) begin
        ctrl_q[CTRL_TF1] <= 1'b1;
      end
    end
  end

  // configuration registers
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      mode_q <= RST_BYTE;
      cksel_q <= RST_BYTE;
      ien_q <= RST_BYTE;
    end else if (bus.wr) begin
      if (bus.addr == ADDR_MODE) begin
        mode_q <= bus.wdata;
      end else if (bus.addr == ADDR_CKSEL) begin
        cksel_q <= bus.wdata;
      end else if (bus.addr == ADDR_IEN) begin
        ien_q <= bus.wdata;
      end
    end
  end

  // read port, data one cycle after strobe
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      rdata_q <= RST_BYTE;
    end else if (bus.rd) begin
      if (bus.addr == ADDR_CTRL) begin
        rdata_q <= ctrl_q;
      end else if (bus.addr == ADDR_MODE) begin
        rdata_q <= mode_q;
      end else if (bus.addr == ADDR_T0L) begin
        rdata_q <= t0l_q;
      end else if (bus.addr == ADDR_T1L) begin
        rdata_q <= t1l_q;
      end else if (bus.addr == ADDR_T0H) begin
        rdata_q <= t0h_q;
      end else if (bus.addr == ADDR_T1H) begin
        rdata_q <= t1h_q;
      end else if (bus.addr == ADDR_CKSEL) begin
        rdata_q <= cksel_q;
      end else if (bus.addr == ADDR_IEN) begin
        rdata_q <= ien_q;
      end else begin
        rdata_q <= RST_BYTE;
      end
    end
  end
  assign RDATA_O = rdata_q;

  // interrupt requests gated by enables
  assign FIRST_IRQ_O = ctrl_q[CTRL_TF0] & ien_q[IEN_ET0];
  assign SECOND_IRQ_O = ctrl_q[CTRL_TF1] & ien_q[IEN_ET1];

  // checks on counting, flags, requests and the register port
  AST_IRQ_GATE: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    (ovf0 && !bus.wr) |=> FIRST_IRQ_O == ien_q[IEN_ET0])
    else $error("first irq does not follow enable");
  AST_IRQ_GATE1: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    (((m0 == MODE_SPLIT) ? ovf0h : ovf1) && !bus.wr) |=> SECOND_IRQ_O == ien_q[IEN_ET1])
    else $error("second irq does not follow enable");
  AST_FLAG_13: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    (m0 == MODE_13BIT && inc0 && t0h_q == 8'hff && t0l_q[4:0] == 5'h1f)
    |=> ctrl_q[CTRL_TF0] && t0h_q == 8'h00 && t0l_q[4:0] == 5'h00)
    else $error("13-bit wrap missed");
  AST_RELOAD: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    (m0 == MODE_8RELOAD && inc0 && t0l_q == 8'hff && !bus.wr)
    |=> t0l_q == $past(t0h_q) && ctrl_q[CTRL_TF0]) else $error("reload wrong");
  AST_STOPPED: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    (!ctrl_q[CTRL_TR0] && m0 != MODE_SPLIT && !bus.wr)
    |=> $stable({t0h_q, t0l_q})) else $error("count while stopped");
  AST_16WRAP: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    (m1 == MODE_16BIT && inc1 && {t1h_q, t1l_q} == 16'hffff && m0 != MODE_SPLIT)
    |=> ctrl_q[CTRL_TF1] && {t1h_q, t1l_q} == 16'h0000) else $error("16-bit wrap");
  AST_SPLIT_STOP: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    (m1 == MODE_SPLIT && !bus.wr) |=> $stable({t1h_q, t1l_q}))
    else $error("second timer runs in split");
  AST_PRE_TICK: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    (pre_tick && pre_sel_q == 2'h1 && $stable(pre_sel_q)) |=> !pre_tick [*3])
    else $error("prescale spacing wrong");
  AST_EVENT: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    (m0 == MODE_16BIT && cfg0.count_sel && !ev0_fall && !bus.wr)
    |=> $stable({t0h_q, t0l_q})) else $error("count without pin edge");
  AST_SPLIT_TF1: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    (m0 == MODE_SPLIT && inc0h && t0h_q == 8'hff && !bus.wr)
    |=> ctrl_q[CTRL_TF1] && t0h_q == 8'h00) else $error("split high byte wrap missed");
  AST_GATE_OFF: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    (cfg0.gate && ext0_q != ien_q[IEN_POL0] && m0 != MODE_SPLIT && !bus.wr)
    |=> $stable({t0h_q, t0l_q})) else $error("count while gated off");
  AST_13_T1: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    (m1 == MODE_13BIT && inc1 && m0 != MODE_SPLIT && !bus.wr &&
    t1h_q == 8'hff && t1l_q[4:0] == 5'h1f)
    |=> ctrl_q[CTRL_TF1] && t1h_q == 8'h00 && t1l_q[4:0] == 5'h00)
    else $error("second 13-bit wrap missed");
  AST_SYS_CLK: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    (m0 == MODE_16BIT && !cfg0.count_sel && cksel_q[CKSEL_T0M] && en0 &&
    t0l_q != 8'hff && !bus.wr) |=> t0l_q == $past(t0l_q) + 8'h01)
    else $error("system clock count wrong");
  AST_EVENT1: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    (m1 == MODE_16BIT && cfg1.count_sel && !ev1_fall && !bus.wr)
    |=> $stable({t1h_q, t1l_q})) else $error("second count without pin edge");
  AST_RD_MODE: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    (bus.rd && bus.addr == ADDR_MODE) |=> RDATA_O == $past(mode_q))
    else $error("mode read wrong");
  AST_BYTE_WR: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    (bus.wr && bus.addr == ADDR_T0L) |=> t0l_q == $past(bus.wdata))
    else $error("low byte write lost");
endmodule : dlct_timers

// ==== tb/dlct_ev_src.sv ====
// event pin source model for the counter inputs
`timescale 1ns/1ns
module dlct_ev_src #(
  parameter int HOLD = 2
) (
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [7:0] num_i,
  output logic pin_o
);
  initial pin_o = 1'b1;
  // falling edges, each level held hold cycles
  always @(posedge clk_i) begin
    if (go_i) begin
      repeat (num_i) begin
        pin_o <= 1'b0;
        repeat (HOLD) @(posedge clk_i);
        pin_o <= 1'b1;
        repeat (HOLD) @(posedge clk_i);
      end
    end
  end
endmodule : dlct_ev_src

// ==== tb/tb_top.sv ====
// self-checking bench for the dual counter/timers
`timescale 1ns/1ns
module tb_top
  import dlct_pkg::*;
;
  logic clk, rst, wr, rd, ext0, ext1, irq0, irq1, go0, go1, pin0, pin1;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, n0, n1;
  logic [1:0] pre;
  int error_cnt, checks, cyc;
  int dv[5] = '{PRE_DIV0, PRE_DIV1, PRE_DIV2, 4, 1};
  dlct_timers uut (.REF_CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .FIRST_EVENT_PIN_I(pin0),
    .SECOND_EVENT_PIN_I(pin1), .FIRST_EXT_INT_I(ext0), .SECOND_EXT_INT_I(ext1),
    .PRESCALE_SELECT_I(pre), .FIRST_IRQ_O(irq0), .SECOND_IRQ_O(irq1));
  dlct_ev_src src0 (.clk_i(clk), .go_i(go0), .num_i(n0), .pin_o(pin0));
  dlct_ev_src src1 (.clk_i(clk), .go_i(go1), .num_i(n1), .pin_o(pin1));
  task automatic wrap_up();
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : wrap_up
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic chk(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi,
                     input string m);
    logic ok;
    ok = (got >= lo) && (got <= hi);
    checks++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("unexpected at %0t: %s got %h", $time, m, got);
    end
  endtask : chk
  task automatic rchk(input logic [3:0] a, input logic [7:0] lo, input logic [7:0] hi,
                      input string m);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    chk(rdata, lo, hi, m);
  endtask : rchk
  task automatic ovf(input logic t, input logic [1:0] m, input logic [7:0] hi,
                     input logic [7:0] lo, input logic [7:0] eh);
    wr_reg(ADDR_MODE, t ? {2'b00, m, 4'h0} : {6'h00, m});
    wr_reg(ADDR_CKSEL, 8'h18);
    wr_reg(ADDR_IEN, 8'h00);
    wr_reg(t ? ADDR_T1H : ADDR_T0H, hi);
    wr_reg(t ? ADDR_T1L : ADDR_T0L, lo);
    wr_reg(ADDR_CTRL, t ? 8'h40 : 8'h10);
    repeat (4) @(posedge clk);
    rchk(ADDR_CTRL, t ? 8'hc0 : 8'h30, t ? 8'hc0 : 8'h30, "flag");
    chk({7'h00, t ? irq1 : irq0}, 8'h00, 8'h00, "irq masked");
    wr_reg(ADDR_IEN, t ? 8'h08 : 8'h02);
    @(posedge clk);
    chk({7'h00, t ? irq1 : irq0}, 8'h01, 8'h01, "irq enabled");
    wr_reg(ADDR_CTRL, 8'h00);
    rchk(t ? ADDR_T1H : ADDR_T0H, eh, eh, "high byte");
  endtask : ovf
  task automatic events(input logic [7:0] a, input logic [7:0] b);
    n0 <= a;
    n1 <= b;
    go0 <= 1'b1;
    go1 <= 1'b1;
    @(posedge clk);
    go0 <= 1'b0;
    go1 <= 1'b0;
    repeat (40) @(posedge clk);
  endtask : events
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      error_cnt++;
      wrap_up();
    end
  end
  initial begin
    {rst, wr, rd, ext0, ext1, go0, go1} = 7'h40;
    {addr, wdata, n0, n1, pre} = '0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 9; i++) rchk(4'(i), 8'h00, 8'h00, "reset value");
    wr_reg(4'h9, 8'hff);
    rchk(4'h9, 8'h00, 8'h00, "unmapped");
    for (int i = 2; i < 6; i++) begin
      wr_reg(4'(i), 8'(8'ha0 + i));
      rchk(4'(i), 8'(8'ha0 + i), 8'(8'ha0 + i), "byte readback");
    end
    for (int i = 0; i < 2; i++) begin
      ovf(i[0], MODE_13BIT, 8'hff, 8'h1f, 8'h00);
      ovf(i[0], MODE_16BIT, 8'hff, 8'hff, 8'h00);
      ovf(i[0], MODE_8RELOAD, 8'h80, 8'hff, 8'h80);
    end
    wr_reg(ADDR_MODE, 8'h55);
    for (int i = 2; i < 6; i++) wr_reg(4'(i), 8'h00);
    wr_reg(ADDR_CTRL, 8'h50);
    events(8'd5, 8'd3);
    rchk(ADDR_T0L, 8'd5, 8'd5, "first event count");
    rchk(ADDR_T1L, 8'd3, 8'd3, "second event count");
    wr_reg(ADDR_MODE, 8'h0d);
    wr_reg(ADDR_IEN, 8'h10);
    wr_reg(ADDR_T0L, 8'h00);
    wr_reg(ADDR_CTRL, 8'h10);
    events(8'd3, 8'd0);
    rchk(ADDR_T0L, 8'd0, 8'd0, "gated off");
    ext0 <= 1'b1;
    repeat (4) @(posedge clk);
    events(8'd3, 8'd0);
    rchk(ADDR_T0L, 8'd3, 8'd3, "gated on");
    for (int i = 0; i < 5; i++) begin
      pre <= i[1:0];
      wr_reg(ADDR_MODE, 8'h01);
      wr_reg(ADDR_CKSEL, i == 4 ? 8'h08 : 8'h00);
      wr_reg(ADDR_T0L, 8'h00);
      wr_reg(ADDR_T0H, 8'h00);
      wr_reg(ADDR_CTRL, 8'h10);
      repeat (96) @(posedge clk);
      wr_reg(ADDR_CTRL, 8'h00);
      rchk(ADDR_T0L, 8'(96 / dv[i] - 1), 8'(96 / dv[i] + 2), "clock source");
    end
    wr_reg(ADDR_MODE, 8'h33);
    wr_reg(ADDR_CKSEL, 8'h08);
    wr_reg(ADDR_T0H, 8'hff);
    wr_reg(ADDR_T0L, 8'h00);
    wr_reg(ADDR_T1L, 8'h00);
    wr_reg(ADDR_CTRL, 8'h40);
    repeat (6) @(posedge clk);
    rchk(ADDR_CTRL, 8'hc0, 8'hc0, "split flag");
    rchk(ADDR_T0L, 8'h00, 8'h00, "split low idle");
    rchk(ADDR_T1L, 8'h00, 8'h00, "second stopped");
    wrap_up();
  end
endmodule : tb_top
